// ==== dm_file_decode.sv ====
// Purpose: resolve a bus address into an effective file address and a region
// Assumes: file address is the APB byte address divided by four
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none

module dm_file_decode (
    input wire logic [11:0] paddr,
    input wire logic [7:0] pointer,
    output logic [6:0] eff_addr,
    output logic self_ref,
    output logic sfr_hit,
    output logic gpr_hit,
    output logic bad_addr
);
    logic [6:0] file_addr;
    logic in_range;

    assign file_addr = paddr[8:2];
    assign in_range = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);

    // address 00h never lands on storage; it borrows the pointer instead
    assign eff_addr = (file_addr == dm_pkg::ADDR_INDIRECT) ? pointer[6:0] : file_addr;
    assign self_ref = (eff_addr == dm_pkg::ADDR_INDIRECT);
    assign sfr_hit = dm_pkg::is_sfr(eff_addr);
    assign gpr_hit = dm_pkg::is_gpr(eff_addr);
    // prohibited holes and words beyond the file are refused
    assign bad_addr = !in_range || !(sfr_hit || gpr_hit);
endmodule

`default_nettype wire

// ==== dm_gpr_ram.sv ====
// Purpose: 48-byte general purpose ram behind the three ram banks
// Assumes: one write port and one asynchronous read port on pclk
// Notes: contents are not reset and are unknown after power-on
`timescale 1ns/1ps
`default_nettype none

module dm_gpr_ram (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [6:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [dm_pkg::GPR_WORDS];

    // caller only strobes we for a file address inside a ram bank
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[dm_pkg::gpr_index(waddr)] <= wdata;
        end
    end

    assign rdata = mem[dm_pkg::gpr_index(raddr)];

    ////////////////////////////////////////////////////////////////////////////////
    property p_ram_keeps_data;
        @(posedge pclk) disable iff (!presetn)
        we |=> mem[dm_pkg::gpr_index($past(waddr))] == $past(wdata);
    endproperty
    a_ram_keeps_data: assert property (p_ram_keeps_data)
        else $error("ram byte did not take the written value");
endmodule

`default_nettype wire

// ==== dm_pkg.sv ====
// Purpose: shared constants and decode helpers for the data memory register file
// Assumes: 7-bit file address space, 8-bit data, one APB word per file address
// Notes: the byte address on APB is four times the file address
`default_nettype none

package dm_pkg;
    localparam int FILE_AW = 7;
    localparam int DATA_W = 8;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int WORD_SHIFT = 2;
    localparam int GPR_WORDS = 48;
    localparam int GPR_IW = 6;

    // file addresses of the special function registers
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [6:0] ADDR_TIMER = 7'h01;
    localparam logic [6:0] ADDR_PCL = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_POINTER = 7'h04;
    localparam logic [6:0] ADDR_PORT_A = 7'h05;
    localparam logic [6:0] ADDR_PORT_B = 7'h06;
    localparam logic [6:0] ADDR_COMP = 7'h07;

    // power-on values; unknown bits are held at zero
    localparam logic [7:0] TIMER_RESET = 8'h00;
    localparam logic [7:0] PCL_RESET = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] POINTER_RESET = 8'h80;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] COMP_RESET = 8'h00;

    // status word fields
    localparam int ST_TO = 4;
    localparam int ST_PD = 3;
    localparam int ST_Z = 2;
    localparam int ST_C = 0;
    localparam logic [7:0] STATUS_IMPL = 8'h1f;
    localparam logic [7:0] PORT_IMPL = 8'h7f;
    localparam logic [7:0] COMP_IMPL = 8'h7f;

    // special registers occupy 00h-07h
    function automatic logic is_sfr(input logic [6:0] a);
        return a[6:3] == 4'h0;
    endfunction

    // ram banks at 10h-1Fh, 30h-3Fh, 50h-5Fh
    function automatic logic is_gpr(input logic [6:0] a);
        return a[4] && (a[6:5] != 2'b11);
    endfunction

    // bank number times sixteen plus the low nibble
    function automatic logic [5:0] gpr_index(input logic [6:0] a);
        return {a[6:5], a[3:0]};
    endfunction
endpackage

`default_nettype wire

// ==== dm_regfile.sv ====
// Purpose: data memory register file of a small 8-bit controller, reached over APB
// Assumes: APB master on pclk; one file register per aligned 32-bit word
// Notes: zero-wait slave; read data is captured in the setup cycle
//
// Summary of operation
// - an access at file address 00h is redirected to the address in the indirect pointer.
// - the indirect pointer lives at 04h and powers up with its top bit set.
// - the comparator and pull-up control register lives at 07h and powers up as zero.
// - ram bytes exist at 10h-1Fh, 30h-3Fh and 50h-5Fh with unknown power-on contents.
// - unimplemented register bits always read back as zero.
// - timer, program counter low, both ports and the pointer are plain file registers; status also takes core-side updates.
// - the low seven pointer bits reach any file address from 00h to 7Fh.
// - through a zero pointer a read gives 00h and a write does nothing.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dm_regfile (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alu_flags_we,
    input wire logic [2:0] alu_flags,
    input wire logic wdt_timeout,
    input wire logic wdt_clear,
    input wire logic stop_entry,
    output logic [7:0] timer_count,
    output logic [7:0] program_counter_low,
    output logic [7:0] alu_status_word,
    output logic [7:0] indirect_pointer,
    output logic [7:0] port_a_data,
    output logic [7:0] port_b_data,
    output logic [7:0] comparator_pullup_control
);
    logic [6:0] eff_addr;
    logic self_ref;
    logic sfr_hit;
    logic gpr_hit;
    logic bad_addr;
    logic setup_rd;
    logic write_go;
    logic [7:0] wbyte;
    logic [7:0] ram_rdata;
    logic [7:0] rd_value;

    ////////////////////////////////////////////////////////////////////////////////
    // address resolution and ram
    dm_file_decode u_decode (
        .paddr(paddr),
        .pointer(indirect_pointer),
        .eff_addr(eff_addr),
        .self_ref(self_ref),
        .sfr_hit(sfr_hit),
        .gpr_hit(gpr_hit),
        .bad_addr(bad_addr)
    );

    dm_gpr_ram u_ram (
        .pclk(pclk),
        .presetn(presetn),
        .we(write_go && gpr_hit),
        .waddr(eff_addr),
        .wdata(wbyte),
        .raddr(eff_addr),
        .rdata(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake: never stalls, so pready is held high
    assign pready = 1'b1;
    assign setup_rd = psel && !penable && !pwrite;
    // a write lands only on the access edge, only to a legal non-self address
    assign write_go = psel && penable && pwrite && pstrb[0] && !bad_addr && !self_ref;
    assign wbyte = pwdata[7:0];
    assign pslverr = psel && penable && bad_addr;

    // read mux; unimplemented bits are masked to zero
    always_comb begin
        rd_value = 8'h00;
        if (self_ref) begin
            rd_value = 8'h00;
        end else if (gpr_hit) begin
            rd_value = ram_rdata;
        end else if (sfr_hit) begin
            unique case (eff_addr[2:0])
                dm_pkg::ADDR_TIMER[2:0]: rd_value = timer_count;
                dm_pkg::ADDR_PCL[2:0]: rd_value = program_counter_low;
                dm_pkg::ADDR_STATUS[2:0]: rd_value = alu_status_word & dm_pkg::STATUS_IMPL;
                dm_pkg::ADDR_POINTER[2:0]: rd_value = indirect_pointer;
                dm_pkg::ADDR_PORT_A[2:0]: rd_value = port_a_data & dm_pkg::PORT_IMPL;
                dm_pkg::ADDR_PORT_B[2:0]: rd_value = port_b_data & dm_pkg::PORT_IMPL;
                dm_pkg::ADDR_COMP[2:0]: rd_value = comparator_pullup_control & dm_pkg::COMP_IMPL;
                default: rd_value = 8'h00;
            endcase
        end
    end

    // read data is taken in setup so that it comes from a flop in the access cycle;
    // prohibited reads give zero, a defined value the core must not rely on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, (bad_addr ? 8'h00 : rd_value)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timer count: plain storage here, the counter itself sits elsewhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= dm_pkg::TIMER_RESET;
        end else if (write_go && eff_addr == dm_pkg::ADDR_TIMER) begin
            timer_count <= wbyte;
        end
    end

    // program counter low byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_low <= dm_pkg::PCL_RESET;
        end else if (write_go && eff_addr == dm_pkg::ADDR_PCL) begin
            program_counter_low <= wbyte;
        end
    end

    // status word: alu update wins over a bus write of the same bits,
    // the time-out and power-down bits follow only their events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu_status_word <= dm_pkg::STATUS_RESET;
        end else begin
            if (alu_flags_we) begin
                alu_status_word[dm_pkg::ST_Z:dm_pkg::ST_C] <= alu_flags;
            end else if (write_go && eff_addr == dm_pkg::ADDR_STATUS) begin
                alu_status_word[dm_pkg::ST_Z:dm_pkg::ST_C] <= wbyte[dm_pkg::ST_Z:dm_pkg::ST_C];
            end
            if (wdt_timeout) begin
                alu_status_word[dm_pkg::ST_TO] <= 1'b0;
            end else if (wdt_clear || stop_entry) begin
                alu_status_word[dm_pkg::ST_TO] <= 1'b1;
            end
            if (stop_entry) begin
                alu_status_word[dm_pkg::ST_PD] <= 1'b0;
            end else if (wdt_clear) begin
                alu_status_word[dm_pkg::ST_PD] <= 1'b1;
            end
            alu_status_word[7:5] <= 3'h0;
        end
    end

    // indirect pointer; only bits 6:0 steer the redirection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indirect_pointer <= dm_pkg::POINTER_RESET;
        end else if (write_go && eff_addr == dm_pkg::ADDR_POINTER) begin
            indirect_pointer <= wbyte;
        end
    end

    // port data latches; bit 7 has no pin behind it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_data <= dm_pkg::PORT_RESET;
            port_b_data <= dm_pkg::PORT_RESET;
        end else if (write_go && eff_addr == dm_pkg::ADDR_PORT_A) begin
            port_a_data <= wbyte & dm_pkg::PORT_IMPL;
        end else if (write_go && eff_addr == dm_pkg::ADDR_PORT_B) begin
            port_b_data <= wbyte & dm_pkg::PORT_IMPL;
        end
    end

    // comparator and pull-up control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_pullup_control <= dm_pkg::COMP_RESET;
        end else if (write_go && eff_addr == dm_pkg::ADDR_COMP) begin
            comparator_pullup_control <= wbyte & dm_pkg::COMP_IMPL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_indirect_write;
        @(posedge pclk) disable iff (!presetn)
        (write_go && paddr[8:2] == dm_pkg::ADDR_INDIRECT
            && indirect_pointer[6:0] == dm_pkg::ADDR_PORT_A)
        |=> port_a_data == {1'b0, $past(pwdata[6:0])};
    endproperty
    a_indirect_write: assert property (p_indirect_write)
        else $error("write through address 00h missed the pointed register");

    property p_pointer_reset;
        @(posedge pclk) $rose(presetn) |-> indirect_pointer[7] == 1'b1;
    endproperty
    a_pointer_reset: assert property (p_pointer_reset)
        else $error("pointer top bit not set after reset");

    property p_comp_reset;
        @(posedge pclk) $rose(presetn) |-> comparator_pullup_control == 8'h00;
    endproperty
    a_comp_reset: assert property (p_comp_reset)
        else $error("comparator control not zero after reset");

    property p_port_msb_zero;
        @(posedge pclk) disable iff (!presetn)
        (setup_rd && !bad_addr && (eff_addr == dm_pkg::ADDR_PORT_A
            || eff_addr == dm_pkg::ADDR_PORT_B || eff_addr == dm_pkg::ADDR_STATUS))
        |=> prdata[7] == 1'b0 && prdata[31:8] == 24'h00_0000;
    endproperty
    a_port_msb_zero: assert property (p_port_msb_zero)
        else $error("unimplemented bit read back as one");

    property p_indirect_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_rd && paddr == 12'h000 && indirect_pointer[6:0] == dm_pkg::ADDR_PCL)
        |=> prdata[7:0] == program_counter_low;
    endproperty
    a_indirect_read: assert property (p_indirect_read)
        else $error("read through pointer did not return the pointed register");

    property p_zero_pointer_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_rd && paddr == 12'h000 && indirect_pointer[6:0] == 7'h00)
        |=> prdata == 32'h0000_0000;
    endproperty
    a_zero_pointer_read: assert property (p_zero_pointer_read)
        else $error("self-referencing read did not return zero");

    property p_zero_pointer_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == 12'h000 && indirect_pointer[6:0] == 7'h00
            && !wdt_clear && !stop_entry && !wdt_timeout && !alu_flags_we)
        |=> $stable(indirect_pointer) && $stable(port_a_data) && $stable(alu_status_word)
            && $stable(timer_count) && $stable(comparator_pullup_control);
    endproperty
    a_zero_pointer_write: assert property (p_zero_pointer_write)
        else $error("self-referencing write changed a register");

    property p_prohibited;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && bad_addr)
        |-> pslverr ##1 ($stable(indirect_pointer) && $stable(program_counter_low)
            && $stable(port_b_data) && $stable(comparator_pullup_control));
    endproperty
    a_prohibited: assert property (p_prohibited)
        else $error("prohibited write was not refused");

    // write landing checks: each register takes its masked byte on the access edge
    property p_timer_write;
        @(posedge pclk) disable iff (!presetn)
        (write_go && eff_addr == dm_pkg::ADDR_TIMER) |=> timer_count == $past(wbyte);
    endproperty
    a_timer_write: assert property (p_timer_write)
        else $error("timer count did not take the written byte");

    property p_pcl_write;
        @(posedge pclk) disable iff (!presetn)
        (write_go && eff_addr == dm_pkg::ADDR_PCL) |=> program_counter_low == $past(wbyte);
    endproperty
    a_pcl_write: assert property (p_pcl_write)
        else $error("program counter low did not take the written byte");

    property p_pointer_write;
        @(posedge pclk) disable iff (!presetn)
        (write_go && eff_addr == dm_pkg::ADDR_POINTER) |=> indirect_pointer == $past(wbyte);
    endproperty
    a_pointer_write: assert property (p_pointer_write)
        else $error("pointer did not take the written byte");

    property p_port_b_write;
        @(posedge pclk) disable iff (!presetn)
        (write_go && eff_addr == dm_pkg::ADDR_PORT_B)
        |=> port_b_data == {1'b0, $past(wbyte[6:0])};
    endproperty
    a_port_b_write: assert property (p_port_b_write)
        else $error("port b data wrong after write");

    property p_comp_write;
        @(posedge pclk) disable iff (!presetn)
        (write_go && eff_addr == dm_pkg::ADDR_COMP)
        |=> comparator_pullup_control == {1'b0, $past(wbyte[6:0])};
    endproperty
    a_comp_write: assert property (p_comp_write)
        else $error("comparator control wrong after write");

    // the time-out and power-down bits must ignore a bus write
    property p_status_write;
        @(posedge pclk) disable iff (!presetn)
        (write_go && eff_addr == dm_pkg::ADDR_STATUS && !alu_flags_we && !wdt_timeout
            && !wdt_clear && !stop_entry)
        |=> alu_status_word[dm_pkg::ST_Z:dm_pkg::ST_C]
            == $past(wbyte[dm_pkg::ST_Z:dm_pkg::ST_C])
            && $stable(alu_status_word[dm_pkg::ST_TO:dm_pkg::ST_PD]);
    endproperty
    a_status_write: assert property (p_status_write)
        else $error("status write touched the wrong bits");

    property p_bad_read_zero;
        @(posedge pclk) disable iff (!presetn)
        (setup_rd && bad_addr) |=> prdata == 32'h0000_0000;
    endproperty
    a_bad_read_zero: assert property (p_bad_read_zero)
        else $error("prohibited read did not return zero");
endmodule

`default_nettype wire

// ==== dm_regfile_bench.sv ====
// Purpose: self-checking bench for the data memory register file over apb
// Assumes: zero-wait slave; file address N sits at byte address 4*N
// Notes: a byte model of the whole file space predicts every read and register output
`timescale 1ns/1ps
`default_nettype none

module dm_regfile_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic alu_flags_we, wdt_timeout, wdt_clear, stop_entry;
    logic [2:0] alu_flags;
    logic [7:0] tmr_o, pcl_o, st_o, ptr_o, pa_o, pb_o, cmp_o;
    logic [7:0] model [0:127];
    logic [6:0] corners [0:8] = '{7'h00, 7'h04, 7'h03, 7'h05, 7'h02, 7'h10, 7'h2a, 7'h5f,
        7'h7f};
    int mismatches = 0;
    int samples_checked = 0;
    logic [31:0] seed_v;

    dm_regfile uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alu_flags_we(alu_flags_we),
        .alu_flags(alu_flags), .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
        .stop_entry(stop_entry), .timer_count(tmr_o), .program_counter_low(pcl_o),
        .alu_status_word(st_o), .indirect_pointer(ptr_o), .port_a_data(pa_o),
        .port_b_data(pb_o), .comparator_pullup_control(cmp_o));

    ////////////////////////////////////////////////////////////////////////////////
    // expectation helpers: the bench keeps its own decode, never the design's

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic is_ram(input logic [6:0] a);
        return a[4] && (a[6:5] != 2'b11);
    endfunction

    // writable bits per file address; status bits 4:3 belong to the core
    function automatic logic [7:0] wmask(input logic [6:0] a);
        case (a)
            7'h01, 7'h02, 7'h04: return 8'hff;
            7'h03: return 8'h07;
            7'h05, 7'h06, 7'h07: return 8'h7f;
            default: return is_ram(a) ? 8'hff : 8'h00;
        endcase
    endfunction

    function automatic logic is_bad(input logic [6:0] a);
        return (a[6:3] != 4'h0) && !is_ram(a);
    endfunction

    function automatic logic [6:0] eff(input logic [6:0] a);
        return (a == 7'h00) ? model[4][6:0] : a;
    endfunction

    task automatic model_reset();
        model[1] = 8'h00;
        model[2] = 8'hff;
        model[3] = 8'h18;
        model[4] = 8'h80;
        model[5] = 8'h00;
        model[6] = 8'h00;
        model[7] = 8'h00;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_outs();
        chk("timer_count", {24'h0, model[1]}, {24'h0, tmr_o});
        chk("program_counter_low", {24'h0, model[2]}, {24'h0, pcl_o});
        chk("alu_status_word", {24'h0, model[3]}, {24'h0, st_o});
        chk("indirect_pointer", {24'h0, model[4]}, {24'h0, ptr_o});
        chk("port_a_data", {24'h0, model[5]}, {24'h0, pa_o});
        chk("port_b_data", {24'h0, model[6]}, {24'h0, pb_o});
        chk("comparator_pullup_control", {24'h0, model[7]}, {24'h0, cmp_o});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // apb master: request held until pready is seen high at a rising edge

    task automatic apb(input logic w, input logic [6:0] fa, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {3'b000, fa, 2'b00};
        pwdata <= {24'($urandom()), wd}; // upper bytes must be ignored
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("[FAIL] pready expected 1 seen %b", pready);
            mismatches++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // write, then update the model the way the file should react
    task automatic wr(input logic [6:0] fa, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        logic [6:0] e;
        e = eff(fa);
        apb(1'b1, fa, d, rd, err);
        chk("pslverr on write", {31'h0, is_bad(e)}, {31'h0, err});
        if (pstrb[0] && e != 7'h00 && !is_bad(e))
            model[e] = (model[e] & ~wmask(e)) | (d & wmask(e));
        #1 check_outs();
    endtask

    task automatic rdchk(input logic [6:0] fa);
        logic [31:0] rd;
        logic err;
        logic [6:0] e;
        e = eff(fa);
        apb(1'b0, fa, 8'h00, rd, err);
        chk("pslverr on read", {31'h0, is_bad(e)}, {31'h0, err});
        chk("prdata", (is_bad(e) || e == 7'h00) ? 32'h0 : {24'h0, model[e]}, rd);
    endtask

    task automatic core(input int k, input logic [2:0] f);
        @(posedge pclk);
        alu_flags_we <= (k == 0);
        alu_flags <= f;
        wdt_timeout <= (k == 1);
        wdt_clear <= (k == 2);
        stop_entry <= (k == 3);
        @(posedge pclk);
        {alu_flags_we, wdt_timeout, wdt_clear, stop_entry} <= 4'h0;
        case (k)
            0: model[3][2:0] = f;
            1: model[3][4] = 1'b0;
            2: model[3][4:3] = 2'b11;
            default: model[3][4:3] = 2'b10;
        endcase
        #1 check_outs();
    endtask

    // reset held eight cycles; outputs must show power-on values meanwhile
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        model_reset();
        check_outs();
        presetn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence

    initial begin
        {presetn, psel, penable, pwrite, alu_flags_we, wdt_timeout, wdt_clear} = 7'h0;
        stop_entry = 1'b0;
        alu_flags = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        seed_v = $urandom(32'h37043e3f);
        do_reset();
        for (int a = 1; a < 8; a++) rdchk(a[6:0]);
        // fill every ram byte and poke every prohibited byte, then read all back
        for (int a = 8; a < 128; a++) wr(a[6:0], 8'($urandom()));
        for (int a = 0; a < 128; a++) rdchk(a[6:0]);
        // special registers with random data; unimplemented bits must read zero
        for (int i = 0; i < 3; i++) begin
            for (int a = 1; a < 8; a++) begin
                wr(a[6:0], 8'($urandom()));
                rdchk(a[6:0]);
            end
        end
        // indirect access through corner and random pointers
        for (int i = 0; i < 27; i++) begin
            wr(7'h04, {1'($urandom()), (i < 9) ? corners[i] : 7'($urandom())});
            wr(7'h00, 8'($urandom()));
            rdchk(7'h00);
            rdchk(model[4][6:0]);
        end
        // a write without the low byte strobe must leave ram untouched
        pstrb <= 4'he;
        wr(7'h35, 8'h5a);
        pstrb <= 4'hf;
        rdchk(7'h35);
        // core side status events, each in turn
        for (int k = 0; k < 4; k++) begin
            core(k, 3'($urandom()));
            rdchk(7'h03);
        end
        // a second reset in mid-run restores the power-on values
        @(posedge pclk);
        do_reset();
        for (int a = 1; a < 8; a++) rdchk(a[6:0]);
        complete_run();
    end
endmodule

`default_nettype wire
